// ### hdl/p6m_map.vh
// p6m_map.vh: offsets, field positions, reset values and mode codes
// for the eight-pin port block; included by every p6m design file.
`ifndef P6M_MAP_VH
`define P6M_MAP_VH

// register byte offsets on the wishbone slave
`define P6M_OFS_DIR 8'h00
`define P6M_OFS_DATA 8'h04
`define P6M_OFS_CTRL 8'h08
`define P6M_OFS_STAT 8'h0C

// reset, read and idle values
`define P6M_DIR_RST 8'h80
`define P6M_LATCH_RST 8'h80
`define P6M_CTRL_RST 3'h0
`define P6M_DIR_READ 8'hFF
`define P6M_BIT7_IDLE 1'h1

// control register fields
`define P6M_CTRL_STOP 0
`define P6M_CTRL_BUS_RELEASE_ENABLE 1
`define P6M_CTRL_WAIT_PIN_ENABLE 2
`define P6M_CTRL_W 3

// status register fields
`define P6M_STAT_MODE_LO 0
`define P6M_STAT_MODE_HI 2
`define P6M_STAT_SWSTBY 3
`define P6M_STAT_EXP 4

// pin positions
`define P6M_PIN_CLK 7
`define P6M_PIN_LWR 6
`define P6M_PIN_HWR 5
`define P6M_PIN_READ 4
`define P6M_PIN_AS 3
`define P6M_PIN_BACK 2
`define P6M_PIN_BUS_REQUEST_IN 1
`define P6M_PIN_WAIT 0

// operating modes: 1 to 5 expanded, 0, 6 and 7 single chip
`define P6M_MODE_FIRST_EXP 3'h1
`define P6M_MODE_LAST_EXP 3'h5

`endif

// ### hdl/p6m_pin_mux.v
// p6m_pin_mux: combinational function select for each of the eight pins.
// assumes the caller registers out_o and oe_o before they reach a pad.
`include "p6m_map.vh"

module p6m_pin_mux (
  input wire expanded_i,
  input wire clock_pin_stop_i,
  input wire bus_release_enable_i,
  input wire wait_pin_enable_i,
  input wire clk_image_i,
  input wire low_byte_write_strobe_n_i,
  input wire high_byte_write_strobe_n_i,
  input wire read_strobe_n_i,
  input wire address_strobe_n_i,
  input wire bus_grant_ack_n_i,
  input wire [7:0] pin_direction_i,
  input wire [7:0] pin_output_latch_i,
  output wire [7:0] out_o,
  output wire [7:0] oe_o
);

  wire [7:0] strobe_n;

  // strobes lined up on their pin numbers, so no index goes negative
  assign strobe_n = {1'h1, low_byte_write_strobe_n_i,
                     high_byte_write_strobe_n_i, read_strobe_n_i,
                     address_strobe_n_i, 3'h7};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      reg out_b;
      reg oe_b;
      always @* begin
        out_b = pin_output_latch_i[gi];
        oe_b = pin_direction_i[gi];
        if (gi == `P6M_PIN_CLK) begin
          out_b = clk_image_i;
          oe_b = ~clock_pin_stop_i;
        end else if (expanded_i && gi >= `P6M_PIN_AS) begin
          out_b = strobe_n[gi];
          oe_b = 1'h1;
        end else if (expanded_i && bus_release_enable_i &&
                     gi == `P6M_PIN_BACK) begin
          out_b = bus_grant_ack_n_i;
          oe_b = 1'h1;
        end else if (expanded_i && bus_release_enable_i &&
                     gi == `P6M_PIN_BUS_REQUEST_IN) begin
          oe_b = 1'h0;
        end else if (expanded_i && wait_pin_enable_i &&
                     gi == `P6M_PIN_WAIT) begin
          // wait is input; a stray direction bit cannot fight it
          oe_b = 1'h0;
        end
      end
      assign out_o[gi] = out_b;
      assign oe_o[gi] = oe_b;
    end
  endgenerate

endmodule // p6m_pin_mux

// ### hdl/p6m_port6.v
// p6m_port6: eight-pin port with direction register, data latch and
// bus pin sharing, reached over a classic wishbone slave.
// assumes pins, strobes and mode straps are synchronous to clk_i.
//
// Functional notes
// - direction register is write-only; reads give all ones
// - direction register resets to 0x80, also on hardware standby
// - software standby holds direction and latch; outputs keep driving
// - general output pins drive their latch bit
// - bit 7 reads one, or pin 7 when clock stopped; writes ignored
// - bits 6..0 read pin when direction 0, latch when 1
// - data latch resets to 0x80, also on hardware standby
// - pin 7 drives clock when stop bit 0, input when 1
// - pin 0 gpio or wait input; software keeps its direction 0
// - single-chip modes: pins 6..0 gpio under their direction bits
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`include "p6m_map.vh"

module p6m_port6 (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [2:0] mode_i,
  input wire hw_standby_i,
  input wire sw_standby_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire low_byte_write_strobe_n_i,
  input wire high_byte_write_strobe_n_i,
  input wire read_strobe_n_i,
  input wire address_strobe_n_i,
  input wire bus_grant_ack_n_i,
  output wire bus_request_in_n_o,
  output wire wait_n_o,
  input wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe_o
);

  reg [7:0] pin_direction_r;
  reg [7:0] pin_direction_nxt;
  reg [7:0] pin_output_latch_r;
  reg [7:0] pin_output_latch_nxt;
  reg [`P6M_CTRL_W-1:0] ctrl_r;
  reg [`P6M_CTRL_W-1:0] ctrl_nxt;
  reg [2:0] mode_r;
  reg clk_image_r;
  reg ack_r;
  reg [31:0] dat_r;
  reg [31:0] dat_nxt;
  reg [7:0] pin_r;
  reg [7:0] pin_oe_r;
  reg bus_request_r;
  reg wait_r;
  reg [7:0] port_read;

  wire init;
  wire access;
  wire wr_lane0;
  wire wr_dir;
  wire wr_data;
  wire wr_ctrl;
  wire hit_dir;
  wire hit_data;
  wire hit_ctrl;
  wire hit_stat;
  wire expanded;
  wire clock_pin_stop;
  wire bus_release_enable;
  wire wait_pin_enable;
  wire [7:0] mux_out;
  wire [7:0] mux_oe;

  // hardware standby clears direction, latch and control bits like reset
  assign init = reset_i | hw_standby_i;
  assign access = wb_cyc_i & wb_stb_i & ~ack_r;
  // a write lands on the edge at which the master sees ack, never
  // earlier, so an abandoned cycle leaves the registers alone
  assign wr_lane0 = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];

  assign hit_dir = (wb_adr_i == `P6M_OFS_DIR);
  assign hit_data = (wb_adr_i == `P6M_OFS_DATA);
  assign hit_ctrl = (wb_adr_i == `P6M_OFS_CTRL);
  assign hit_stat = (wb_adr_i == `P6M_OFS_STAT);

  assign clock_pin_stop = ctrl_r[`P6M_CTRL_STOP];
  assign bus_release_enable = ctrl_r[`P6M_CTRL_BUS_RELEASE_ENABLE];
  assign wait_pin_enable = ctrl_r[`P6M_CTRL_WAIT_PIN_ENABLE];

  assign wr_dir = wr_lane0 & hit_dir & ~sw_standby_i;
  assign wr_data = wr_lane0 & hit_data & ~sw_standby_i;
  assign wr_ctrl = wr_lane0 & hit_ctrl & ~sw_standby_i;

  assign expanded = (mode_r >= `P6M_MODE_FIRST_EXP) &&
                    (mode_r <= `P6M_MODE_LAST_EXP);

  // mode straps caught while reset is held, steady afterwards
  always @(posedge clk_i) begin
    if (ce_i && reset_i) begin
      mode_r <= mode_i;
    end
  end

  // direction register next value
  always @* begin
    pin_direction_nxt = pin_direction_r;
    if (wr_dir) begin
      pin_direction_nxt = {1'h1, wb_dat_i[6:0]};
    end
  end

  // data latch next value
  always @* begin
    pin_output_latch_nxt = pin_output_latch_r;
    if (wr_data) begin
      pin_output_latch_nxt = {`P6M_BIT7_IDLE, wb_dat_i[6:0]};
    end
  end

  // control bits next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wb_dat_i[`P6M_CTRL_W-1:0];
    end
  end

  // direction register; hardware standby clears it like reset
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (init) begin
        pin_direction_r <= `P6M_DIR_RST;
      end else begin
        pin_direction_r <= pin_direction_nxt;
      end
    end
  end

  // data latch; hardware standby clears it like reset
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (init) begin
        pin_output_latch_r <= `P6M_LATCH_RST;
      end else begin
        pin_output_latch_r <= pin_output_latch_nxt;
      end
    end
  end

  // control bits; stopping the clock pin is undone by hardware standby too
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (init) begin
        ctrl_r <= `P6M_CTRL_RST;
      end else begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  // port read value as software sees it
  always @* begin
    port_read = 8'h00;
    if (clock_pin_stop) begin
      port_read[7] = pin_i[7];
    end else begin
      port_read[7] = `P6M_BIT7_IDLE;
    end
    port_read[6:0] = (pin_direction_r[6:0] & pin_output_latch_r[6:0]) |
                     (~pin_direction_r[6:0] & pin_i[6:0]);
  end

  // read data decode; unmapped offsets answer with zero
  always @* begin
    dat_nxt = 32'h00000000;
    if (hit_dir) begin
      dat_nxt[7:0] = `P6M_DIR_READ;
    end else if (hit_data) begin
      dat_nxt[7:0] = port_read;
    end else if (hit_ctrl) begin
      dat_nxt[`P6M_CTRL_W-1:0] = ctrl_r;
    end else if (hit_stat) begin
      dat_nxt[`P6M_STAT_MODE_HI:`P6M_STAT_MODE_LO] = mode_r;
      dat_nxt[`P6M_STAT_SWSTBY] = sw_standby_i;
      dat_nxt[`P6M_STAT_EXP] = expanded;
    end
  end

  // one wait state: ack the cycle after the strobe, drop it after
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        ack_r <= 1'h0;
      end else begin
        ack_r <= access;
      end
    end
  end

  // read data caught at the take edge, held until the next read
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        dat_r <= 32'h00000000;
      end else if (access && !wb_we_i) begin
        dat_r <= dat_nxt;
      end
    end
  end

  // free-running clock image: half rate, since a pad output must
  // come from a flip-flop and cannot carry clk_i itself
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        clk_image_r <= 1'h0;
      end else begin
        clk_image_r <= ~clk_image_r;
      end
    end
  end

  p6m_pin_mux u_mux (
    .expanded_i(expanded),
    .clock_pin_stop_i(clock_pin_stop),
    .bus_release_enable_i(bus_release_enable),
    .wait_pin_enable_i(wait_pin_enable),
    .clk_image_i(clk_image_r),
    .low_byte_write_strobe_n_i(low_byte_write_strobe_n_i),
    .high_byte_write_strobe_n_i(high_byte_write_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i),
    .address_strobe_n_i(address_strobe_n_i),
    .bus_grant_ack_n_i(bus_grant_ack_n_i),
    .pin_direction_i(pin_direction_r),
    .pin_output_latch_i(pin_output_latch_r),
    .out_o(mux_out),
    .oe_o(mux_oe)
  );

  // pad drivers registered; standby changes nothing here on purpose
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        pin_r <= 8'h00;
        pin_oe_r <= 8'h00;
      end else begin
        pin_r <= mux_out;
        pin_oe_r <= mux_oe;
      end
    end
  end

  // bus request from pin 1, idle high when not selected
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        bus_request_r <= 1'h1;
      end else if (expanded && bus_release_enable) begin
        bus_request_r <= pin_i[`P6M_PIN_BUS_REQUEST_IN];
      end else begin
        bus_request_r <= 1'h1;
      end
    end
  end

  // wait from pin 0, idle high so a gpio pin never stalls the bus
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (reset_i) begin
        wait_r <= 1'h1;
      end else if (expanded && wait_pin_enable) begin
        wait_r <= pin_i[`P6M_PIN_WAIT];
      end else begin
        wait_r <= 1'h1;
      end
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign pin_o = pin_r;
  assign pin_oe_o = pin_oe_r;
  assign bus_request_in_n_o = bus_request_r;
  assign wait_n_o = wait_r;

endmodule // p6m_port6

// ### sim/p6m_board.sv
// p6m_board: board around the port pins, pull-ups on every line.
// assumes the device drives a pin only while its enable is high.
module p6m_board (
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o,
  input wire [7:0] ext_oe_i,
  input wire [7:0] ext_val_i,
  output wire [7:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // wait line yields
  // the outside drive only wins where the device lets go; the
  // released line floats up, not to its last value
  assign pin_lvl_o = (pin_oe_o & pin_o) |
    (~pin_oe_o & ext_oe_i & ext_val_i) | (~pin_oe_o & ~ext_oe_i);
endmodule // p6m_board

// ### sim/p6m_port6_props.sv
// p6m_port6_props: port-level checks on the port block.
// assumes ce_i stays high and mode_i changes only in reset.
module p6m_port6_props (
  input wire clk_i,
  input wire reset_i,
  input wire [2:0] mode_i,
  input wire hw_standby_i,
  input wire sw_standby_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire low_byte_write_strobe_n_i,
  input wire high_byte_write_strobe_n_i,
  input wire read_strobe_n_i,
  input wire address_strobe_n_i,
  input wire bus_request_in_n_o,
  input wire wait_n_o,
  input wire [7:0] pin_i,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire single = (mode_i >= 3'h6) || (mode_i == 3'h0);
  wire [3:0] strb = {low_byte_write_strobe_n_i, high_byte_write_strobe_n_i,
    read_strobe_n_i, address_strobe_n_i};
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    s_take ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  a_ack_next: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dir_ones: assert property (s_rd(8'h00) |=> wb_dat_o == 32'h000000FF)
    else $error("direction read not all ones");
  a_bit7_read: assert property (s_rd(8'h04) |=>
    wb_dat_o[7] == ($past(pin_oe_o[7]) | $past(pin_i[7])))
    else $error("bit 7 read wrong");
  a_strobe_route: assert property (!single && !$past(reset_i) |->
    pin_oe_o[6:3] == 4'hF && pin_o[6:3] == $past(strb))
    else $error("strobe pins wrong");
  a_clk_toggle: assert property (pin_oe_o[7] && $past(pin_oe_o[7]) &&
    $past(pin_oe_o[7], 2) |-> pin_o[7] != $past(pin_o[7]))
    else $error("clock pin not toggling");
  a_wait_idle: assert property (pin_oe_o[0] |-> wait_n_o)
    else $error("wait active on output pin");
  a_bus_request_in_idle: assert property (pin_oe_o[1] |-> bus_request_in_n_o)
    else $error("request active on output pin");
  a_sw_hold: assert property (sw_standby_i && !hw_standby_i && single |->
    ##2 $stable(pin_oe_o[6:0]) && $stable(pin_o[6:0]))
    else $error("pins moved in standby");
  a_hw_clear: assert property (hw_standby_i && single |->
    ##2 (pin_oe_o[6:0] | pin_o[6:0]) == 7'h00)
    else $error("hardware standby not cleared");
endmodule // p6m_port6_props

// ### sim/port6_io_and_bus_pin_mux_test.sv
// port6_io_and_bus_pin_mux_test: directed bench for the port block.
// assumes the board model resolves the pins; ce_i held high.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end

module port6_io_and_bus_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, reset_i = 1, hw = 0, sw = 0, cyc = 0, stb = 0, we = 0;
  logic [2:0] mode = 3'h7;
  logic [3:0] strb = 4'hA;
  logic gnt = 0, ack, bus_request_in_n, wait_n;
  logic [7:0] adr = 0, xoe = 8'hFF, xval = 8'h2A, q, lvl, pin_o, pin_oe;
  logic [31:0] dat = 0, rdat;
  int mismatches = 0, n_tests = 0;
  initial forever #10 clk_i = ~clk_i;
  p6m_port6 i_p6m_port6 (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .mode_i(mode), .hw_standby_i(hw), .sw_standby_i(sw), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .low_byte_write_strobe_n_i(strb[3]), .high_byte_write_strobe_n_i(strb[2]),
    .read_strobe_n_i(strb[1]), .address_strobe_n_i(strb[0]),
    .bus_grant_ack_n_i(gnt), .bus_request_in_n_o(bus_request_in_n), .wait_n_o(wait_n),
    .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe));
  p6m_board i_p6m_board (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_oe_i(xoe),
    .ext_val_i(xval), .pin_lvl_o(lvl));
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one classic cycle; two idle edges after it, since a write lands at
  // the ack edge and the pads follow one edge later
  task automatic wbt(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin mismatches++; end_of_test(); end
      @(posedge clk_i);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rst(input logic [2:0] m);
    reset_i <= 1'b1;
    mode <= m;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_reset();
    wbt(0, 8'h00, 8'h00); `CHK(q, 8'hFF)
    wbt(0, 8'h04, 8'h00); `CHK(q, 8'hAA)
    `CHK(pin_oe[7], 1'b1)
    wbt(0, 8'h10, 8'h00); `CHK(q, 8'h00)
  endtask
  task automatic t_gpio();
    wbt(1, 8'h00, 8'h0F);
    wbt(1, 8'h04, 8'hF5);
    `CHK(pin_oe[6:0], 7'h0F)
    `CHK(pin_o[3:0], 4'h5)
    wbt(0, 8'h04, 8'h00); `CHK(q, 8'hA5)
  endtask
  task automatic t_standby();
    sw <= 1'b1;
    wbt(1, 8'h00, 8'h00);
    wbt(1, 8'h04, 8'h00);
    `CHK(pin_oe[6:0], 7'h0F)
    `CHK(pin_o[3:0], 4'h5)
    sw <= 1'b0;
    hw <= 1'b1;
    @(posedge clk_i);
    hw <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(pin_oe[6:0], 7'h00)
    wbt(1, 8'h00, 8'h7F);
    wbt(0, 8'h04, 8'h00); `CHK(q, 8'h80)
  endtask
  task automatic t_stop();
    wbt(1, 8'h08, 8'h01); `CHK(pin_oe[7], 1'b0)
    wbt(0, 8'h04, 8'h00); `CHK(q, 8'h00)
  endtask
  task automatic t_expanded();
    rst(3'h1);
    gnt <= 1'h1;
    xval <= 8'h28;
    `CHK(pin_oe[6:3], 4'hF)
    `CHK(pin_o[6:3], strb)
    strb <= 4'h5;
    repeat (2) @(posedge clk_i);
    `CHK(pin_o[6:3], 4'h5)
    wbt(0, 8'h0C, 8'h00); `CHK(q, 8'h11)
    // direction bit 0 kept clear while wait is used
    wbt(1, 8'h00, 8'h06);
    wbt(1, 8'h08, 8'h06);
    wbt(0, 8'h08, 8'h00); `CHK(q, 8'h06)
    `CHK(pin_oe[2:0], 3'h4)
    `CHK(pin_o[2], gnt)
    `CHK(bus_request_in_n, xval[1])
    `CHK(wait_n, xval[0])
  endtask
  initial begin
    rst(3'h7);
    t_reset();
    t_gpio();
    t_standby();
    t_stop();
    t_expanded();
    end_of_test();
  end
endmodule // port6_io_and_bus_pin_mux_test

bind p6m_port6 p6m_port6_props i_p6m_port6_props (.*);
